// file: spsw_map.svh
// register addresses, field positions, reset values and timing counts of the serial port
`ifndef SPSW_MAP_SVH
`define SPSW_MAP_SVH
`define SPSW_ADDR_STATUS 32'hffff0a00
`define SPSW_ADDR_RXDATA 32'hffff0a04
`define SPSW_ADDR_TXDATA 32'hffff0a08
`define SPSW_ADDR_DIVISOR 32'hffff0a0c
`define SPSW_ADDR_CONTROL 32'hffff0a10
`define SPSW_STATUS_RST 16'h0000
`define SPSW_CONTROL_RST 16'h0000
`define SPSW_DIVISOR_RST 8'h1b
`define SPSW_CTL_EN 0
`define SPSW_CTL_MASTER 1
`define SPSW_CTL_CPOL 2
`define SPSW_CTL_CPHA 3
`define SPSW_CTL_TIM 4
`define SPSW_CTL_RXFL 12
`define SPSW_CTL_TXFL 13
`define SPSW_CTL_THR_HI 15
`define SPSW_CTL_THR_LO 14
`define SPSW_ST_REX 11
`define SPSW_ST_RXC_HI 10
`define SPSW_ST_RXC_LO 8
`define SPSW_ST_OVF 7
`define SPSW_ST_RXIRQ 6
`define SPSW_ST_TXIRQ 5
`define SPSW_ST_TXUF 4
`define SPSW_ST_TXC_HI 3
`define SPSW_ST_TXC_LO 1
`define SPSW_ST_ANY 0
`define SPSW_LAST_BIT 3'h7
`define SPSW_LAST_HALF 4'hf
`define SPSW_RESP_OKAY 2'b00
`define SPSW_RESP_SLVERR 2'b10
`endif

// file: spsw_pkg.sv
// types shared by the serial port design
package spsw_pkg;
   typedef enum logic [1:0] {
      SPSW_IDLE = 2'b01,
      SPSW_RUN = 2'b10
   } spsw_state_e;
   typedef struct packed {
      logic [1:0] thr;
      logic tx_flush;
      logic rx_flush;
      logic tim;
      logic cpha;
      logic cpol;
      logic master;
      logic en;
   } spsw_cfg_s;
   typedef struct packed {
      logic ovf;
      logic rxirq;
      logic txirq;
      logic txuf;
      logic any;
   } spsw_flags_s;
endpackage

// file: spsw_port.sv
// full-duplex byte-wide serial port, master or slave, with axi4-lite register slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "spsw_map.svh"
module spsw_port import spsw_pkg::*; #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // axi4-lite write channels
   input logic [31:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // axi4-lite read channels
   input logic [31:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // serial clock pin
   input logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   // chip select pin, active low
   input logic chip_select_pin_n_in,
   output logic chip_select_pin_n_out,
   output logic chip_select_pin_n_oe,
   // data lines
   input logic master_in_line_in,
   output logic master_in_line_out,
   output logic master_in_line_oe,
   input logic master_out_line_in,
   output logic master_out_line_out,
   output logic master_out_line_oe
);
   localparam logic [2:0] DEPTH_C = 3'(FIFO_DEPTH);
   localparam logic [1:0] LAST_PTR = 2'(FIFO_DEPTH - 1);

   // refuse depths that the two-bit pointers cannot address
   if (FIFO_DEPTH < 1 || FIFO_DEPTH > 4) begin : g_bad_depth
      $error("fifo depth must lie between 1 and 4");
   end

   function automatic logic [1:0] adv(input logic [1:0] p);
      return (p == LAST_PTR) ? 2'h0 : p + 2'h1;
   endfunction

   // register file and bus state
   logic [15:0] ctl_r, ctl_nxt;
   logic [7:0] div_r, div_nxt;
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [31:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_fire, rd_fire, rx_rd, tx_wr, stat_rd;
   spsw_cfg_s cfg;
   // fifo and flag state
   logic [FIFO_DEPTH-1:0][7:0] rx_mem_r, rx_mem_nxt, tx_mem_r, tx_mem_nxt;
   logic [1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt, tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
   logic [2:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt, thr_cnt;
   spsw_flags_s flags_r, flags_nxt;
   logic rx_excess, ovf_ev, rxirq_ev, any_ev;
   logic [15:0] status_w;
   // serial engine state
   spsw_state_e state_r, state_nxt;
   logic [7:0] divcnt_r, divcnt_nxt, txs_r, txs_nxt, rxs_r, rxs_nxt, rx_byte;
   logic [3:0] halfcnt_r, halfcnt_nxt;
   logic [2:0] bitcnt_r, bitcnt_nxt;
   logic [1:0] txbytes_r, txbytes_nxt;
   logic sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, cont_r, cont_nxt;
   logic sclk_prev_r, sclk_prev_nxt, cs_prev_r, cs_prev_nxt;
   logic pend_r, pend_nxt;
   logic din, tick, lead, trail, sample, launch, sedge, byte_done, more;
   logic m_start, s_start, load, tx_pop, rx_push, txuf_ev, txirq_ev;

   // control fields
   assign cfg = '{thr: ctl_r[`SPSW_CTL_THR_HI:`SPSW_CTL_THR_LO], tx_flush: ctl_r[`SPSW_CTL_TXFL],
                  rx_flush: ctl_r[`SPSW_CTL_RXFL], tim: ctl_r[`SPSW_CTL_TIM], cpha: ctl_r[`SPSW_CTL_CPHA],
                  cpol: ctl_r[`SPSW_CTL_CPOL], master: ctl_r[`SPSW_CTL_MASTER], en: ctl_r[`SPSW_CTL_EN]};

   // bus handshakes and decoded accesses
   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready = !w_hold_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
   assign rd_fire = s_axi_arvalid && !rvalid_r;
   assign rx_rd = rd_fire && (s_axi_araddr == `SPSW_ADDR_RXDATA);
   assign stat_rd = rd_fire && (s_axi_araddr == `SPSW_ADDR_STATUS);
   assign tx_wr = wr_fire && (awaddr_r == `SPSW_ADDR_TXDATA) && wstrb_r[0];

   // status word assembly
   always_comb begin
      status_w = `SPSW_STATUS_RST;
      status_w[`SPSW_ST_REX] = rx_excess;
      status_w[`SPSW_ST_RXC_HI:`SPSW_ST_RXC_LO] = rx_cnt_r;
      status_w[`SPSW_ST_OVF] = flags_r.ovf;
      status_w[`SPSW_ST_RXIRQ] = flags_r.rxirq;
      status_w[`SPSW_ST_TXIRQ] = flags_r.txirq;
      status_w[`SPSW_ST_TXUF] = flags_r.txuf;
      status_w[`SPSW_ST_TXC_HI:`SPSW_ST_TXC_LO] = tx_cnt_r;
      status_w[`SPSW_ST_ANY] = flags_r.any;
   end

   // bus slave next state: write capture, register writes, read answers
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      awaddr_nxt = awaddr_r;
      w_hold_nxt = w_hold_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      ctl_nxt = ctl_r;
      div_nxt = div_r;
      if (s_axi_awvalid && !aw_hold_r) begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_r) begin
         w_hold_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_fire) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = `SPSW_RESP_OKAY;
         case (awaddr_r)
            `SPSW_ADDR_CONTROL: begin
               if (wstrb_r[0]) ctl_nxt[7:0] = wdata_r[7:0];
               if (wstrb_r[1]) ctl_nxt[15:8] = wdata_r[15:8];
            end
            `SPSW_ADDR_DIVISOR: begin
               if (wstrb_r[0]) div_nxt = wdata_r[7:0];
            end
            `SPSW_ADDR_STATUS, `SPSW_ADDR_RXDATA, `SPSW_ADDR_TXDATA: begin
               bresp_nxt = `SPSW_RESP_OKAY; // read-only writes ignored, tx push elsewhere
            end
            default: bresp_nxt = `SPSW_RESP_SLVERR;
         endcase
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_fire) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `SPSW_RESP_OKAY;
         case (s_axi_araddr)
            `SPSW_ADDR_STATUS: rdata_nxt = {16'h0000, status_w};
            `SPSW_ADDR_RXDATA: rdata_nxt = {24'h000000, (rx_cnt_r != 3'h0) ? rx_mem_r[rx_rp_r] : 8'h00};
            `SPSW_ADDR_TXDATA: rdata_nxt = 32'h00000000;
            `SPSW_ADDR_DIVISOR: rdata_nxt = {24'h000000, div_r};
            `SPSW_ADDR_CONTROL: rdata_nxt = {16'h0000, ctl_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = `SPSW_RESP_SLVERR;
            end
         endcase
      end
   end

   // bus slave registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         awaddr_r <= 32'h00000000;
         w_hold_r <= 1'b0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `SPSW_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= `SPSW_RESP_OKAY;
         rdata_r <= 32'h00000000;
         ctl_r <= `SPSW_CONTROL_RST;
         div_r <= `SPSW_DIVISOR_RST;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         awaddr_r <= awaddr_nxt;
         w_hold_r <= w_hold_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         ctl_r <= ctl_nxt;
         div_r <= div_nxt;
      end
   end

   // threshold in bytes, one to four
   assign thr_cnt = {1'b0, cfg.thr} + 3'h1;
   assign rx_excess = rx_cnt_r > thr_cnt;

   // fifos, events and sticky flags
   always_comb begin
      rx_mem_nxt = rx_mem_r;
      rx_wp_nxt = rx_wp_r;
      rx_rp_nxt = rx_rp_r;
      rx_cnt_nxt = rx_cnt_r;
      tx_mem_nxt = tx_mem_r;
      tx_wp_nxt = tx_wp_r;
      tx_rp_nxt = tx_rp_r;
      tx_cnt_nxt = tx_cnt_r;
      ovf_ev = rx_push && (rx_cnt_r == DEPTH_C);
      rxirq_ev = 1'b0;
      if (rx_push && !ovf_ev) begin
         rx_mem_nxt[rx_wp_r] = rx_byte;
         rx_wp_nxt = adv(rx_wp_r);
         rx_cnt_nxt = rx_cnt_nxt + 3'h1;
         rxirq_ev = !cfg.tim && ((rx_cnt_r + 3'h1) >= thr_cnt);
      end
      if (rx_rd && (rx_cnt_r != 3'h0)) begin
         rx_rp_nxt = adv(rx_rp_r);
         rx_cnt_nxt = rx_cnt_nxt - 3'h1;
      end
      if (tx_wr && !cfg.tx_flush && (tx_cnt_r != DEPTH_C)) begin
         tx_mem_nxt[tx_wp_r] = wdata_r[7:0];
         tx_wp_nxt = adv(tx_wp_r);
         tx_cnt_nxt = tx_cnt_nxt + 3'h1;
      end
      if (tx_pop) begin
         tx_rp_nxt = adv(tx_rp_r);
         tx_cnt_nxt = tx_cnt_nxt - 3'h1;
      end
      // a held flush keeps the fifo empty
      if (cfg.rx_flush) begin
         rx_wp_nxt = 2'h0;
         rx_rp_nxt = 2'h0;
         rx_cnt_nxt = 3'h0;
      end
      if (cfg.tx_flush) begin
         tx_wp_nxt = 2'h0;
         tx_rp_nxt = 2'h0;
         tx_cnt_nxt = 3'h0;
      end
      any_ev = (ovf_ev && !cfg.rx_flush) || rxirq_ev || txirq_ev || (txuf_ev && !cfg.tx_flush);
      // a status read clears, a same-cycle event sets and wins
      flags_nxt = stat_rd ? '0 : flags_r;
      flags_nxt.ovf = flags_nxt.ovf || ovf_ev;
      flags_nxt.rxirq = flags_nxt.rxirq || rxirq_ev;
      flags_nxt.txirq = flags_nxt.txirq || txirq_ev;
      flags_nxt.txuf = flags_nxt.txuf || txuf_ev;
      flags_nxt.any = flags_nxt.any || any_ev;
   end

   // fifo and flag registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_mem_r <= '0;
         rx_wp_r <= 2'h0;
         rx_rp_r <= 2'h0;
         rx_cnt_r <= 3'h0;
         tx_mem_r <= '0;
         tx_wp_r <= 2'h0;
         tx_rp_r <= 2'h0;
         tx_cnt_r <= 3'h0;
         flags_r <= '0;
      end else begin
         rx_mem_r <= rx_mem_nxt;
         rx_wp_r <= rx_wp_nxt;
         rx_rp_r <= rx_rp_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         tx_mem_r <= tx_mem_nxt;
         tx_wp_r <= tx_wp_nxt;
         tx_rp_r <= tx_rp_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         flags_r <= flags_nxt;
      end
   end

   // serial engine: edges, shifting, byte framing and master clock generation
   always_comb begin
      din = cfg.master ? master_in_line_in : master_out_line_in;
      tick = cfg.master && (state_r == SPSW_RUN) && (divcnt_r == div_r);
      sedge = !cfg.master && (state_r == SPSW_RUN) && !chip_select_pin_n_in
              && (serial_clock_pin_in != sclk_prev_r);
      lead = (tick && (sclk_r == cfg.cpol)) || (sedge && (serial_clock_pin_in != cfg.cpol));
      trail = (tick && (sclk_r != cfg.cpol)) || (sedge && (serial_clock_pin_in == cfg.cpol));
      sample = cfg.cpha ? trail : lead;
      launch = cfg.cpha ? lead : trail;
      byte_done = sample && (bitcnt_r == `SPSW_LAST_BIT);
      rx_byte = {rxs_r[6:0], din};
      rx_push = byte_done && !cfg.rx_flush;
      more = cfg.master ? (cfg.tim && (tx_cnt_r != 3'h0)) : 1'b1;
      m_start = cfg.en && cfg.master && (state_r == SPSW_IDLE) && (cfg.tim ? (tx_cnt_r != 3'h0) : rx_rd);
      s_start = cfg.en && !cfg.master && (state_r == SPSW_IDLE) && !chip_select_pin_n_in && cs_prev_r;
      load = m_start || s_start || (pend_r && launch);
      tx_pop = load && (tx_cnt_r != 3'h0);
      txuf_ev = load && (tx_cnt_r == 3'h0);
      state_nxt = state_r;
      divcnt_nxt = divcnt_r;
      halfcnt_nxt = halfcnt_r;
      bitcnt_nxt = bitcnt_r;
      txs_nxt = txs_r;
      rxs_nxt = rxs_r;
      sclk_nxt = sclk_r;
      cont_nxt = cont_r;
      txbytes_nxt = txbytes_r;
      pend_nxt = pend_r;
      txirq_ev = 1'b0;
      sclk_prev_nxt = serial_clock_pin_in;
      cs_prev_nxt = chip_select_pin_n_in;
      if (sample) begin
         rxs_nxt = rx_byte;
         bitcnt_nxt = bitcnt_r + 3'h1;
      end
      if (launch && (bitcnt_r != 3'h0)) begin
         txs_nxt = {txs_r[6:0], 1'b0};
      end
      if (load) begin
         txs_nxt = tx_pop ? tx_mem_r[tx_rp_r] : 8'h00;
         pend_nxt = 1'b0;
      end
      // a following byte waits for the next launch edge, so the line never moves at a sample edge
      if (byte_done) begin
         pend_nxt = more;
      end
      if (!cfg.tim) begin
         txbytes_nxt = 2'h0;
      end else if (byte_done) begin
         txirq_ev = (txbytes_r == cfg.thr);
         txbytes_nxt = txirq_ev ? 2'h0 : txbytes_r + 2'h1;
      end
      case (state_r)
         SPSW_IDLE: begin
            sclk_nxt = cfg.cpol;
            pend_nxt = 1'b0;
            divcnt_nxt = 8'h00;
            halfcnt_nxt = 4'h0;
            if (m_start || s_start) begin
               state_nxt = SPSW_RUN;
               bitcnt_nxt = 3'h0;
               cont_nxt = 1'b0;
            end
         end
         SPSW_RUN: begin
            if (tick) begin
               divcnt_nxt = 8'h00;
               sclk_nxt = !sclk_r;
               halfcnt_nxt = halfcnt_r + 4'h1;
               if ((halfcnt_r == `SPSW_LAST_HALF) && !(byte_done ? more : cont_r)) begin
                  state_nxt = SPSW_IDLE;
               end
            end else if (cfg.master) begin
               divcnt_nxt = divcnt_r + 8'h01;
            end
            if (byte_done) begin
               cont_nxt = more;
            end
            if (!cfg.en || (!cfg.master && chip_select_pin_n_in)) begin
               state_nxt = SPSW_IDLE;
               bitcnt_nxt = 3'h0;
            end
         end
         default: state_nxt = SPSW_IDLE;
      endcase
      cs_n_nxt = (state_nxt != SPSW_RUN);
   end

   // serial engine registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= SPSW_IDLE;
         divcnt_r <= 8'h00;
         halfcnt_r <= 4'h0;
         bitcnt_r <= 3'h0;
         txs_r <= 8'h00;
         rxs_r <= 8'h00;
         sclk_r <= 1'b0;
         cs_n_r <= 1'b1;
         cont_r <= 1'b0;
         txbytes_r <= 2'h0;
         sclk_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
         pend_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         divcnt_r <= divcnt_nxt;
         halfcnt_r <= halfcnt_nxt;
         bitcnt_r <= bitcnt_nxt;
         txs_r <= txs_nxt;
         rxs_r <= rxs_nxt;
         sclk_r <= sclk_nxt;
         cs_n_r <= cs_n_nxt;
         cont_r <= cont_nxt;
         txbytes_r <= txbytes_nxt;
         sclk_prev_r <= sclk_prev_nxt;
         cs_prev_r <= cs_prev_nxt;
         pend_r <= pend_nxt;
      end
   end

   // pin drivers and directions
   assign serial_clock_pin_out = sclk_r;
   assign serial_clock_pin_oe = cfg.en && cfg.master;
   assign chip_select_pin_n_out = cs_n_r;
   assign chip_select_pin_n_oe = cfg.en && cfg.master;
   assign master_out_line_out = txs_r[7];
   assign master_out_line_oe = cfg.en && cfg.master;
   assign master_in_line_out = txs_r[7];
   assign master_in_line_oe = cfg.en && !cfg.master && !chip_select_pin_n_in;

   // checks beside the logic
   AST_SCLK_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg.master && state_r == SPSW_IDLE) |=> serial_clock_pin_out == $past(cfg.cpol))
      else $error("master serial clock not at idle polarity");
   AST_SCLK_HALF: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && state_nxt == SPSW_RUN) |=> (serial_clock_pin_out != $past(serial_clock_pin_out)) && divcnt_r == 8'h00)
      else $error("serial clock did not toggle after divisor count");
   AST_BYTE_END: assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg.master && state_r == SPSW_RUN ##1 state_r == SPSW_IDLE && cfg.master && cfg.en) |-> $past(halfcnt_r) == 4'hf)
      else $error("master transfer ended off a byte boundary");
   AST_CS_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg.master && m_start) |=> !chip_select_pin_n_out && chip_select_pin_n_oe)
      else $error("chip select not asserted at transfer start");
   AST_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
      cfg.master |-> !master_in_line_oe && (serial_clock_pin_oe == cfg.en))
      else $error("pin direction wrong in master mode");
   AST_OVF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_ev |=> flags_r.ovf && rx_cnt_r == $past(rx_cnt_r) - ($past(rx_rd) ? 3'h1 : 3'h0))
      else $error("overflow not flagged or full fifo changed");
   AST_UF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      (txuf_ev && !cfg.tx_flush) |=> flags_r.txuf && flags_r.any && txs_r == 8'h00)
      else $error("underflow not flagged");
   AST_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      (stat_rd && !any_ev) |=> !flags_r.any ##1 (s_axi_rdata[0] == $past(flags_r.any, 2)))
      else $error("status read did not clear or return flags");
   AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
      (stat_rd && any_ev) |=> flags_r.any)
      else $error("event lost against status read");
   AST_COUNTS: assert property (@(posedge aclk) disable iff (!aresetn)
      (rx_cnt_r <= DEPTH_C) && (tx_cnt_r <= DEPTH_C))
      else $error("fifo count beyond depth");
   AST_REX_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      stat_rd |=> s_axi_rdata[11] == ($past(rx_cnt_r) > $past(thr_cnt)))
      else $error("excess bit disagrees with fifo count");
endmodule // spsw_port

// file: spsw_far_slave.sv
// far-side serial slave: mode 0, returns a fixed byte, collects the byte sent
`timescale 1ns/1ps
module spsw_far_slave (
   // serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // byte to return, last byte seen, bytes done
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output int nb
);
   logic [8:0] sh_out = 9'h0;
   logic [7:0] sh_in = 8'h0;
   int bits = 0;
   initial begin
      miso = 1'b0;
      nb = 0;
      rx_byte = 8'h0;
   end
   // frame start: first bit goes out before the first edge
   always @(negedge cs_n) begin
      sh_out = {tx_byte, 1'b0};
      miso = tx_byte[7];
      bits = 0;
   end
   // released line shows the inverse of its last bit
   always @(posedge cs_n) miso = ~miso;
   // sample on the leading edge, reload after eight
   always @(posedge sclk) if (!cs_n) begin
      sh_in = {sh_in[6:0], mosi};
      bits++;
      if (bits % 8 == 0) begin
         rx_byte = sh_in;
         nb++;
         sh_out = {1'b0, tx_byte};
      end
   end
   // launch on the trailing edge
   always @(negedge sclk) if (!cs_n) begin
      sh_out = {sh_out[7:0], 1'b0};
      miso = sh_out[8];
   end
endmodule // spsw_far_slave

// file: spi_port_with_status_tb_top.sv
// bench: register bus master, far slave and read-data checks
`timescale 1ns/1ps
`include "spsw_map.svh"
module spi_port_with_status_tb_top;
   logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wrd, bv, arr, rv, sco, scoe, cso, csoe;
   logic mio, mioe, moo, mooe, pm, sq = 1'b0;
   logic msck = 1'b0, mcsn = 1'b1, mmosi = 1'b0;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0] bresp, rresp;
   logic [7:0] sb, lastb, prx, mrx, zb;
   logic [33:0] q[$];
   int err_total = 0, compares = 0, seed, nb, cyc = 0, lr = 0, per = 0, i;
   // pin levels from the port's output enables
   wire sck = scoe ? sco : msck;
   wire csn = csoe ? cso : mcsn;
   wire miso = mioe ? mio : pm;
   wire mosi = mooe ? moo : mmosi;
   spsw_port uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rready), .serial_clock_pin_in(sck), .serial_clock_pin_out(sco),
      .serial_clock_pin_oe(scoe), .chip_select_pin_n_in(csn), .chip_select_pin_n_out(cso),
      .chip_select_pin_n_oe(csoe), .master_in_line_in(miso), .master_in_line_out(mio),
      .master_in_line_oe(mioe), .master_out_line_in(mosi), .master_out_line_out(moo),
      .master_out_line_oe(mooe));
   spsw_far_slave far (.sclk(sck), .cs_n(csn), .mosi(mosi), .miso(pm), .tx_byte(sb), .rx_byte(prx), .nb(nb));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task cmp(input string n, input logic [33:0] e, input logic [33:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task guard(input bit ok);
      if (!ok) begin
         err_total++;
         final_report();
      end
   endtask
   // one write: address and data released as each is taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awv, wv, bready} <= 3'b111;
      do begin
         @(posedge aclk);
         n++;
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end while (!bv && n < 200);
      bready <= 1'b0;
      guard(n < 200);
   endtask
   // one read, expected response and data noted first
   task automatic rd(input logic [31:0] a, input logic [33:0] e);
      int n = 0;
      q.push_back(e);
      @(posedge aclk);
      araddr <= a;
      {arv, rready} <= 2'b11;
      do begin
         @(posedge aclk);
         n++;
         if (arr) arv <= 1'b0;
      end while (!rv && n < 200);
      rready <= 1'b0;
      guard(n < 200);
   endtask
   // far master frame in mode 3, 14 cycles a bit keeps it under 10 Mb; launch falling, sample rising
   task automatic mframe(input logic [7:0] d);
      int b;
      @(posedge aclk);
      mcsn <= 1'b0;
      for (b = 7; b >= 0; b--) begin
         repeat (7) @(posedge aclk);
         msck <= 1'b0;
         mmosi <= d[b];
         repeat (7) @(posedge aclk);
         msck <= 1'b1;
         mrx <= {mrx[6:0], miso};
      end
      repeat (7) @(posedge aclk);
      mcsn <= 1'b1;
   endtask
   task automatic wait_bytes(input int k);
      int n;
      for (n = 0; n < 3000 && nb < k; n++) @(posedge aclk);
      guard(n < 3000);
      repeat (4) @(posedge aclk);
   endtask
   // read results against the oldest note; clock rise spacing
   always @(posedge aclk) begin
      if (rv && rready) cmp("rdata", q.pop_front(), {rresp, rdata});
      cyc <= cyc + 1;
      sq <= sco;
      if (sco && !sq) begin
         per <= cyc - lr;
         lr <= cyc;
      end
   end
   initial begin
      seed = 32'h4c3a;
      {aresetn, awv, wv, bready, arv, rready} = 6'h0;
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      sb = 8'($random(seed));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SPSW_ADDR_STATUS, {18'h0, `SPSW_STATUS_RST});
      rd(`SPSW_ADDR_CONTROL + 32'h10, {`SPSW_RESP_SLVERR, 32'h0});
      $display("test reset and map done");
      wr(`SPSW_ADDR_DIVISOR, 32'h2);
      wr(`SPSW_ADDR_CONTROL, 32'hc012);
      for (i = 0; i < 4; i++) begin
         lastb = 8'($random(seed));
         wr(`SPSW_ADDR_TXDATA, {24'h0, lastb});
      end
      rd(`SPSW_ADDR_STATUS, {18'h0, 16'h0008});
      wr(`SPSW_ADDR_CONTROL, 32'hc013);
      wait_bytes(4);
      lastb = 8'($random(seed));
      wr(`SPSW_ADDR_TXDATA, {24'h0, lastb});
      wait_bytes(5);
      rd(`SPSW_ADDR_STATUS, {18'h0, 16'h04a1});
      rd(`SPSW_ADDR_STATUS, {18'h0, 16'h0400});
      cmp("far rx", {26'h0, lastb}, {26'h0, prx});
      cmp("period", 34'd6, 34'(per));
      for (i = 0; i < 4; i++) rd(`SPSW_ADDR_RXDATA, {26'h0, sb});
      $display("test master burst done");
      wr(`SPSW_ADDR_CONTROL, 32'h0003);
      rd(`SPSW_ADDR_RXDATA, 34'h0);
      wait_bytes(6);
      rd(`SPSW_ADDR_STATUS, {18'h0, 16'h0151});
      cmp("far rx", 34'h0, {26'h0, prx});
      $display("test underflow done");
      msck <= 1'b1;
      wr(`SPSW_ADDR_CONTROL, 32'h000d);
      lastb = 8'($random(seed));
      zb = 8'($random(seed));
      wr(`SPSW_ADDR_TXDATA, {24'h0, lastb});
      mframe(zb);
      rd(`SPSW_ADDR_STATUS, {18'h0, 16'h0a41});
      cmp("far master rx", {26'h0, lastb}, {26'h0, mrx});
      rd(`SPSW_ADDR_RXDATA, {26'h0, sb});
      rd(`SPSW_ADDR_RXDATA, {26'h0, zb});
      $display("test slave mode 3 done");
      final_report();
   end
endmodule // spi_port_with_status_tb_top
